// ==== verilog/amsc_top.sv ====
// Converter sequencing, done flag and multiplexer address control
`timescale 1ns/10ps
`include "amsc_cfg.svh"
//==========================================================
// Overview of operation
// - Standalone, a convert request pulse on the start input begins conversion.
// - With a host, an I/O transfer instruction begins conversion.
// - Each manual convert button press begins a new conversion.
// - Word length selector sets 6 to 12 bits and the step count.
// - Result is offset code: zero volts 4000, full negative 0000.
// - Done shows on two complementary outputs at conversion end.
// - Done holds until a clear pulse or a new convert request.
// - Host read buffer command clears done.
// - No recovery time; a new start is accepted right after finishing.
// - Channel count is a multiple of four, one to sixteen groups.
// - Random mode connects the channel on the random address inputs.
// - Sequential mode adds one to the address per step command.
// - Stepping from the highest channel wraps to zero.
// - Sequential mode ignores the random address inputs.
// - Manual zero button forces channel zero.
// - Manual step button advances like a step command.
// - Current address shows on six indicator outputs.
// - Without a converter the manual convert button does nothing.
module amsc_top
   import amsc_pkg::*;
#(
   parameter int  GROUPS        = 16,  // Switch groups of four channels
   parameter bit  HAS_CONVERTER = 1'b1 // Converter fitted
) (
   input  wire logic             ref_clk,        // 50 MHz clock
   input  wire logic             rst,            // Sync reset, active high
   input  wire amsc_ctrl_type    ctrl,           // Start and clear requests
   input  wire logic [3:0]       word_length,    // Selected bits, 6..12
   input  wire logic             compare_above,  // Comparator: input above trial
   input  wire amsc_mux_cmd_type mux_cmd,        // Multiplexer commands
   output logic [11:0]           trial_code,     // Trial code to the DAC
   output logic [11:0]           result,         // Converted result
   output logic                  done,           // Done flag
   output logic                  done_n,         // Complement of done
   output logic                  busy,           // Conversion in progress
   output logic [5:0]            channel_address // Address and indicators
);
   //==========================================================
   // Usage notes
   // All start sources are merged into one request; any of them
   // restarts a conversion in progress, so a caller that pulses twice
   // simply loses the first conversion.
   // The word length is taken at the start edge only; moving the
   // selector mid-conversion has no effect until the next start.
   // Selector values outside 6..12 are clamped rather than refused,
   // so a stray code still gives a bounded conversion time.
   // The comparator input is read on every busy cycle; it must be
   // settled against the trial word of the previous edge.
   // The result is left justified: a short word leaves the low bits
   // at zero, so the host reads the same scale at every length.
   // Done drops on the start edge and rises on the edge that resolves
   // the last bit; it is never high while busy.
   // End of conversion beats a clear in the same cycle, so a late
   // clear cannot hide a fresh result from the reader.
   // A start beats both, so done never reports a stale result.
   // The zero button beats every other address command, which lets
   // an operator recover the sequence at any time.
   // In random mode the address follows the random inputs each cycle
   // unless a step arrives; codes above the last fitted channel are
   // clamped so an unfitted switch group is never selected.
   // The address indicators are the address register itself, so the
   // panel always shows the channel really in use.
   // Without a converter fitted the manual convert button is masked
   // at the decode, and nothing else changes.
   // There is no buffering: a result stands only until the next
   // completion, so the reader must keep pace with the starts.
   //==========================================================
   // Derived values
   localparam logic [5:0] LAST_CH = 6'((GROUPS * 4) - 1);

   amsc_state_type state;
   logic [3:0]  bit_idx;
   logic [3:0]  steps_left;
   logic [3:0]  wl_eff;
   logic        start_req;
   logic        clear_req;
   logic        button_start;
   logic        step_req;

   //==========================================================
   // Request decode
   assign button_start = ctrl.start_button & HAS_CONVERTER;
   assign start_req = ctrl.start_pulse
                    | ctrl.host_io_transfer_instruction
                    | button_start;
   assign clear_req = ctrl.clear_flag | ctrl.host_read_buffer;
   assign step_req  = mux_cmd.step_command | mux_cmd.step_button;

   // Clamp selector into the legal range
   always_comb begin
      if (word_length < `AMSC_WL_MIN) begin
         wl_eff = `AMSC_WL_MIN;
      end else if (word_length > `AMSC_WL_MAX) begin
         wl_eff = `AMSC_WL_MAX;
      end else begin
         wl_eff = word_length;
      end
   end

   //==========================================================
   // Successive approximation sequencer
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state      <= AMSC_IDLE;
         bit_idx    <= `AMSC_MSB_IDX;
         steps_left <= `AMSC_STEPS_ZERO;
         trial_code <= `AMSC_RES_ZERO;
      end else if (start_req) begin
         // A new start restarts at once, even right after finishing
         state      <= AMSC_CONV;
         bit_idx    <= `AMSC_MSB_IDX;
         steps_left <= wl_eff;
         trial_code <= `AMSC_MID_CODE;
      end else begin
         case (state)
            AMSC_IDLE: begin
               state <= AMSC_IDLE;
            end
            AMSC_CONV: begin
               // Keep or drop the trial bit, then try the next one
               if (!compare_above) begin
                  trial_code[bit_idx] <= 1'b0;
               end
               if (steps_left == `AMSC_IDX_ONE) begin
                  state <= AMSC_IDLE;
               end else begin
                  trial_code[bit_idx - `AMSC_IDX_ONE] <= 1'b1;
                  bit_idx    <= bit_idx - `AMSC_IDX_ONE;
                  steps_left <= steps_left - `AMSC_IDX_ONE;
               end
            end
            default: begin
               state <= AMSC_IDLE;
            end
         endcase
      end
   end

   assign busy = (state == AMSC_CONV);

   //==========================================================
   // Result capture, offset code kept in the top bits
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         result <= `AMSC_RES_ZERO;
      end else if (busy && !start_req && steps_left == `AMSC_IDX_ONE) begin
         // Bit 11 set means at or above zero volts, giving 4000 octal
         result <= compare_above ? trial_code
                                 : (trial_code & ~(`AMSC_BIT_ONE << bit_idx));
      end
   end

   //==========================================================
   // Done flag; end of conversion wins over a clear in the same cycle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         done <= 1'b0;
      end else if (start_req) begin
         done <= 1'b0;
      end else if (busy && steps_left == `AMSC_IDX_ONE) begin
         done <= 1'b1;
      end else if (clear_req) begin
         done <= 1'b0;
      end
   end

   assign done_n = ~done;

   //==========================================================
   // Multiplexer address controller, also the indicator drive
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         channel_address <= `AMSC_ADDR_ZERO;
      end else if (mux_cmd.manual_channel_zero_button) begin
         channel_address <= `AMSC_ADDR_ZERO;
      end else if (mux_cmd.sequential_mode) begin
         // Random inputs ignored here
         if (step_req) begin
            if (channel_address >= LAST_CH) begin
               channel_address <= `AMSC_ADDR_ZERO;
            end else begin
               channel_address <= channel_address + `AMSC_ADDR_ONE;
            end
         end
      end else if (step_req) begin
         // Manual step also advances in random mode
         channel_address <= (channel_address >= LAST_CH) ? `AMSC_ADDR_ZERO
                                : channel_address + `AMSC_ADDR_ONE;
      end else begin
         channel_address <= (mux_cmd.random_address > LAST_CH) ? LAST_CH
                                : mux_cmd.random_address;
      end
   end

   //==========================================================
   // Check helpers: busy cycle count and latched word length
   logic [3:0]  busy_run;
   logic [3:0]  wl_taken;
   logic [11:0] low_mask;

   // Count busy cycles since the last start
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         busy_run <= `AMSC_STEPS_ZERO;
      end else if (start_req) begin
         busy_run <= `AMSC_STEPS_ZERO;
      end else if (busy) begin
         busy_run <= busy_run + `AMSC_IDX_ONE;
      end
   end

   // Word length in force for the current conversion
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wl_taken <= `AMSC_WL_MIN;
      end else if (start_req) begin
         wl_taken <= wl_eff;
      end
   end

   // Result bits below the selected word length
   assign low_mask = `AMSC_ALL_ONES >> wl_taken;

   //==========================================================
   // Checks
   done_low_busy_a: assert property (@(posedge ref_clk) disable iff (rst)
      busy |-> !done) else $error("done high during conversion");
   done_compl_a: assert property (@(posedge ref_clk) disable iff (rst)
      done_n == !done) else $error("done outputs not complementary");
   start_clears_a: assert property (@(posedge ref_clk) disable iff (rst)
      start_req |=> !done && busy) else $error("start did not clear done");
   clear_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
      (clear_req && !start_req && !busy) |=> !done) else $error("clear ignored");
   conv_len_a: assert property (@(posedge ref_clk) disable iff (rst)
      (start_req && word_length == 4'h6) ##1 (!start_req)[*6] |=> done)
      else $error("six bit conversion length wrong");
   done_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
      (done && !start_req && !clear_req) |=> done) else $error("done dropped");
   seq_step_a: assert property (@(posedge ref_clk) disable iff (rst)
      (mux_cmd.sequential_mode && step_req && !mux_cmd.manual_channel_zero_button
       && channel_address < LAST_CH) |=> channel_address == $past(channel_address) + 6'h01)
      else $error("step did not add one");
   seq_wrap_a: assert property (@(posedge ref_clk) disable iff (rst)
      (step_req && !mux_cmd.manual_channel_zero_button && channel_address == LAST_CH)
      |=> channel_address == 6'h00) else $error("no wrap to zero");
   zero_btn_a: assert property (@(posedge ref_clk) disable iff (rst)
      mux_cmd.manual_channel_zero_button |=> channel_address == 6'h00)
      else $error("zero button ignored");
   seq_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
      (mux_cmd.sequential_mode && !step_req && !mux_cmd.manual_channel_zero_button)
      |=> $stable(channel_address)) else $error("random inputs used in sequence");
   // External convert pulse starts at the mid-scale trial word
   pulse_start_a: assert property (@(posedge ref_clk) disable iff (rst)
      ctrl.start_pulse |=> busy && trial_code == `AMSC_MID_CODE)
      else $error("convert pulse did not start");
   // Host transfer instruction starts a conversion
   host_start_a: assert property (@(posedge ref_clk) disable iff (rst)
      ctrl.host_io_transfer_instruction |=> busy)
      else $error("host start ignored");
   // Manual button starts a conversion when fitted
   button_start_a: assert property (@(posedge ref_clk) disable iff (rst)
      (ctrl.start_button && HAS_CONVERTER) |=> busy)
      else $error("button start ignored");
   // Manual button alone does nothing without a converter
   button_dead_a: assert property (@(posedge ref_clk) disable iff (rst)
      (!HAS_CONVERTER && ctrl.start_button && !ctrl.start_pulse
       && !ctrl.host_io_transfer_instruction && !busy) |=> !busy)
      else $error("button started without converter");
   // Clamped word length stays in range
   wl_range_a: assert property (@(posedge ref_clk) disable iff (rst)
      wl_eff >= `AMSC_WL_MIN && wl_eff <= `AMSC_WL_MAX)
      else $error("word length out of range");
   // Conversion takes one cycle per bit
   conv_steps_a: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(done) |-> busy_run == wl_taken)
      else $error("conversion step count wrong");
   // Bits below the word length read zero
   result_lsbs_a: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(done) |-> (result & low_mask) == `AMSC_RES_ZERO)
      else $error("unused result bits set");
   // Result stands outside conversions
   result_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
      !busy |=> $stable(result))
      else $error("result changed while idle");
   // Last bit raises done and ends busy
   done_rise_a: assert property (@(posedge ref_clk) disable iff (rst)
      (busy && !start_req && steps_left == `AMSC_IDX_ONE) |=> done && !busy)
      else $error("done not raised at end");
   // Complement output high while converting
   done_n_busy_a: assert property (@(posedge ref_clk) disable iff (rst)
      busy |-> done_n)
      else $error("done complement low while busy");
   // Done never overlaps busy
   done_busy_a: assert property (@(posedge ref_clk) disable iff (rst)
      done |-> !busy)
      else $error("busy with done high");
   // Read buffer clears done
   read_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
      (ctrl.host_read_buffer && !busy) |=> !done)
      else $error("read buffer did not clear");
   // Start accepted right after completion
   no_recovery_a: assert property (@(posedge ref_clk) disable iff (rst)
      (done && start_req) |=> busy)
      else $error("start refused after done");
   // Idle stays idle without a start
   idle_stays_a: assert property (@(posedge ref_clk) disable iff (rst)
      (!busy && !start_req) |=> !busy)
      else $error("busy without start");
   // Trial word frozen while idle
   idle_trial_a: assert property (@(posedge ref_clk) disable iff (rst)
      (!busy && !start_req) |=> $stable(trial_code))
      else $error("trial changed while idle");
   // Busy never outlasts the word length
   busy_len_a: assert property (@(posedge ref_clk) disable iff (rst)
      busy |-> busy_run < wl_taken)
      else $error("busy too long");
   // Bits resolved from the top down
   bit_order_a: assert property (@(posedge ref_clk) disable iff (rst)
      (busy && !start_req && steps_left != `AMSC_IDX_ONE)
      |=> bit_idx == $past(bit_idx) - `AMSC_IDX_ONE)
      else $error("bit order wrong");
   // Every start tries the mid-scale word first
   mid_trial_a: assert property (@(posedge ref_clk) disable iff (rst)
      start_req |=> trial_code == `AMSC_MID_CODE)
      else $error("first trial not mid scale");
   // Random mode follows the random inputs
   rand_load_a: assert property (@(posedge ref_clk) disable iff (rst)
      (!mux_cmd.sequential_mode && !step_req && !mux_cmd.manual_channel_zero_button
       && mux_cmd.random_address <= LAST_CH)
      |=> channel_address == $past(mux_cmd.random_address))
      else $error("random address not loaded");
   // Unfitted random codes clamp to the last channel
   rand_clamp_a: assert property (@(posedge ref_clk) disable iff (rst)
      (!mux_cmd.sequential_mode && !step_req && !mux_cmd.manual_channel_zero_button
       && mux_cmd.random_address > LAST_CH)
      |=> channel_address == LAST_CH)
      else $error("random address not clamped");
   // Address never beyond the fitted channels
   addr_range_a: assert property (@(posedge ref_clk) disable iff (rst)
      channel_address <= LAST_CH)
      else $error("address beyond last channel");
   // Manual step button advances by one
   step_button_a: assert property (@(posedge ref_clk) disable iff (rst)
      (mux_cmd.step_button && !mux_cmd.manual_channel_zero_button
       && channel_address < LAST_CH)
      |=> channel_address == $past(channel_address) + `AMSC_ADDR_ONE)
      else $error("step button did not advance");
endmodule : amsc_top

// ==== verilog/amsc_cfg.svh ====
// Constants for the converter and multiplexer sequencing control
`ifndef AMSC_CFG_SVH
`define AMSC_CFG_SVH
`define AMSC_WL_MIN      4'h6
`define AMSC_WL_MAX      4'hc
`define AMSC_ADDR_W      6
`define AMSC_ADDR_ZERO   6'h00
`define AMSC_ADDR_ONE    6'h01
`define AMSC_MID_CODE    12'h800
`define AMSC_RES_ZERO    12'h000
`define AMSC_BIT_ONE     12'h001
`define AMSC_MSB_IDX     4'hb
`define AMSC_IDX_ONE     4'h1
`define AMSC_STEPS_ZERO  4'h0
`define AMSC_ALL_ONES    12'hfff
`endif

// ==== verilog/amsc_pkg.sv ====
// Types for the converter and multiplexer sequencing control
package amsc_pkg;
   // Conversion sequencer states
   typedef enum logic [1:0] {
      AMSC_IDLE,
      AMSC_CONV
   } amsc_state_type;

   // Start and clear request group
   typedef struct packed {
      logic start_pulse;
      logic start_button;
      logic host_io_transfer_instruction;
      logic clear_flag;
      logic host_read_buffer;
   } amsc_ctrl_type;

   // Multiplexer command group
   typedef struct packed {
      logic       sequential_mode;
      logic [5:0] random_address;
      logic       step_command;
      logic       step_button;
      logic       manual_channel_zero_button;
   } amsc_mux_cmd_type;
endpackage : amsc_pkg

// ==== tb/amsc_far_model.sv ====
// Far-side model: analog input level seen through the comparator
`timescale 1ns/10ps
module amsc_far_model (
   input  wire logic [11:0] level,         // Input level as a 12-bit code
   input  wire logic [11:0] trial_code,    // Trial word from the design
   output logic             compare_above  // High when input at or above trial
);
   // Comparator decision for the successive approximation steps
   assign compare_above = (level >= trial_code);
endmodule : amsc_far_model

// ==== tb/tb.sv ====
// Self-checking bench for the converter and multiplexer control
`timescale 1ns/10ps
module tb;
   import amsc_pkg::*;
   //==========================================================
   // Signals
   logic             ref_clk = 1'b0;
   logic             rst = 1'b1;
   amsc_ctrl_type    ctrl = '0;
   amsc_mux_cmd_type mux = '0;
   logic [3:0]       wl = 4'hc;
   logic [11:0]      level = 12'h000;
   logic             cmp, done, done_n, busy;
   logic [11:0]      trial, result;
   logic [5:0]       chan;
   int               bad_count = 0, checks_done = 0, seed = 46, ea = 0;
   int               lv[3] = '{0, 2048, 4095};
   //==========================================================
   // Design, far side and clock
   amsc_top #(.GROUPS(4), .HAS_CONVERTER(1'b1)) DUT (.ref_clk(ref_clk), .rst(rst),
      .ctrl(ctrl), .word_length(wl), .compare_above(cmp), .mux_cmd(mux),
      .trial_code(trial), .result(result), .done(done), .done_n(done_n),
      .busy(busy), .channel_address(chan));
   amsc_far_model far (.level(level), .trial_code(trial), .compare_above(cmp));
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end
   //==========================================================
   // Shared tasks
   task automatic step();
      @(posedge ref_clk);
      #1;
   endtask : step
   task automatic check(string what, logic [11:0] seen, logic [11:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done
   // One conversion from the given start source
   task automatic convert(logic [4:0] src, logic [11:0] lvl, int w);
      int cnt;
      level = lvl;
      wl = 4'(w);
      ctrl = src;
      step();
      ctrl = '0;
      cnt = 1;
      while (done !== 1'b1 && cnt < 20) begin
         check("busy", 12'(busy), 12'h001);
         check("done_low", 12'(done), 12'h000);
         step();
         cnt++;
      end
      if (cnt >= 20) begin
         bad_count++;
         test_done();
      end else begin
         check("cycles", 12'(cnt), 12'(w + 1));
         check("result", result, 12'((lvl >> (12 - w)) << (12 - w)));
         check("done_n", 12'(done_n), 12'h000);
      end
   endtask : convert
   //==========================================================
   // Main sequence
   initial begin
      repeat (4) step();
      rst = 1'b0;
      check("rst_done", 12'(done), 12'h000);
      check("rst_chan", 12'(chan), 12'h000);
      for (int w = 6; w <= 12; w++) begin
         convert(5'h10, 12'($random(seed)), w);
         convert(5'h04, 12'(lv[w % 3]), w);
         convert(5'h08, 12'(lv[(w + 1) % 3]), w);
      end
      $display("test conversions done");
      repeat (3) step();
      check("done_hold", 12'(done), 12'h001);
      ctrl.clear_flag = 1'b1;
      step();
      ctrl = '0;
      check("clear", 12'(done), 12'h000);
      convert(5'h10, 12'h800, 12);
      ctrl.host_read_buffer = 1'b1;
      step();
      ctrl = '0;
      check("read_clr", 12'(done), 12'h000);
      $display("test done flag finished");
      for (int i = 0; i < 8; i++) begin
         ea = $random(seed) & 15;
         mux.random_address = 6'(ea);
         step();
         check("random_ch", 12'(chan), 12'(ea));
      end
      mux.sequential_mode = 1'b1;
      mux.manual_channel_zero_button = 1'b1;
      step();
      mux.manual_channel_zero_button = 1'b0;
      check("zero_btn", 12'(chan), 12'h000);
      ea = 0;
      for (int i = 0; i < 20; i++) begin
         mux.random_address = 6'($random(seed));
         mux.step_command = i[0];
         mux.step_button = ~i[0];
         step();
         ea = (ea + 1) % 16;
         check("seq_ch", 12'(chan), 12'(ea));
      end
      mux.step_command = 1'b0;
      mux.step_button = 1'b0;
      step();
      check("seq_hold", 12'(chan), 12'(ea));
      $display("test multiplexer done");
      test_done();
   end
endmodule : tb
